// ---- verilog/asbl_pkg.sv ----
// Purpose: Constants for the host-side controller of an asynchronous byte-lane static memory.
// Assumes: Controller clock of 10 MHz, one cycle is 100 ns.
// Notes: Access times follow the slowest speed grade so any fitted part is served.
package asbl_pkg;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Slowest grade: cycle 70 ns, write pulse 60 ns, data valid after output enable 70 ns.
  localparam int unsigned T_CYCLE_NS = 70;
  localparam int unsigned T_WPULSE_NS = 60;
  localparam int unsigned T_RDATA_NS = 70;
  localparam int unsigned T_HZ_NS = 25;
  localparam int unsigned CYC_CYCLE = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WPULSE = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RDATA = (T_RDATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_HZ = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [1:0] LANES_NONE = 2'h0;
  typedef enum logic [2:0] {
    ASBL_IDLE = 3'h0,
    ASBL_SETUP = 3'h1,
    ASBL_RD = 3'h3,
    ASBL_WR = 3'h5,
    ASBL_END = 3'h7,
    ASBL_RECOV = 3'h2
  } asbl_state_t;
endpackage

// ---- verilog/asbl_host.sv ----
// Purpose: Host controller driving an asynchronous 512K x 16 static memory with byte lanes.
// Assumes: One request at a time; i_req is held with its fields until o_ack.
// Notes: Strobes and data come from flip-flops so no pin glitches between edges.
// Operation
// - A write lasts only while selects, write strobe and a lane gate are all active and ends with the first to drop.
// - Write data setup and hold are timed against the signal that ends the write.
// - The host must not drive data while the memory may still drive after output enable was low.
// - Address is valid no later than the selects and lane gates going active for a read.
// - The word address is 19 bits; lower gate covers bits 0 to 7, upper gate bits 8 to 15.
`timescale 1ns/1ps
`default_nettype none
module asbl_host #(
  parameter int unsigned CYCLE_CYC = asbl_pkg::CYC_CYCLE,
  parameter int unsigned WPULSE_CYC = asbl_pkg::CYC_WPULSE,
  parameter int unsigned RDATA_CYC = asbl_pkg::CYC_RDATA,
  parameter int unsigned HZ_CYC = asbl_pkg::CYC_HZ
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [asbl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [1:0] i_lanes,
  input wire logic [asbl_pkg::DATA_W-1:0] i_wdata,
  output logic o_ack,
  output logic [asbl_pkg::DATA_W-1:0] o_rdata,
  output logic o_busy,
  output logic [asbl_pkg::ADDR_W-1:0] o_mem_addr,
  output logic o_select_active_low,
  output logic o_select_active_high,
  output logic o_write_n,
  output logic o_out_en_n,
  output logic o_upper_lane_gate_n,
  output logic o_lower_lane_gate_n,
  output logic [asbl_pkg::DATA_W-1:0] o_mem_dq,
  output logic o_mem_dq_oe,
  input wire logic [asbl_pkg::DATA_W-1:0] i_mem_dq
);
  // Each access runs through SETUP, then RD, or WR and END, then RECOV for the bus to float.
  // The address is registered one cycle ahead of the selects, so it is always settled
  // before any select or lane gate turns active, for reads and writes alike.
  // Selects, lane gates and the write strobe turn on at the same edge; the strobe is
  // the first to drop, so it alone ends every write and the data is held past it.
  // Timing counts are whole clock cycles rounded up from the slowest speed grade,
  // which wastes some time on faster parts but serves every part that fits.
  // A limitation: only one access is outstanding and requests during an access are
  // ignored, so the requester must hold its fields until the acknowledge.
  // Read data is sampled through two flip-flops, which adds their delay to each read.
  localparam int unsigned LW = asbl_pkg::LANE_W;
  localparam logic [asbl_pkg::CNT_W-1:0] CNT_ONE = asbl_pkg::CNT_W'(1);

  asbl_pkg::asbl_state_t state_q, state_d;
  logic [asbl_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [asbl_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [asbl_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] lanes_q, lanes_d;
  logic we_q, we_d;
  logic sel_q, sel_d;
  logic wstb_q, wstb_d;
  logic oe_q, oe_d;
  logic dqoe_q, dqoe_d;
  logic ack_q, ack_d;
  logic [asbl_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic [asbl_pkg::DATA_W-1:0] dq_s1_d, dq_s2_d;

  // Memory data passes two flip-flops; read data is taken only well after it has settled.
  always_comb begin
    dq_s1_d = i_mem_dq;
    dq_s2_d = dq_s1_q;
  end

  always_ff @(posedge i_clk) begin
    dq_s1_q <= dq_s1_d;
    dq_s2_q <= dq_s2_d;
  end

  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q != '0) ? cnt_q - CNT_ONE : cnt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    lanes_d = lanes_q;
    we_d = we_q;
    sel_d = sel_q;
    wstb_d = wstb_q;
    oe_d = oe_q;
    dqoe_d = dqoe_q;
    ack_d = 1'b0;
    case (state_q)
      asbl_pkg::ASBL_IDLE: begin
        if (i_req && i_lanes != asbl_pkg::LANES_NONE) begin
          // Address is latched one cycle before any select or gate goes active.
          addr_d = i_addr;
          lanes_d = i_lanes;
          we_d = i_we;
          wdata_d = i_wdata;
          state_d = asbl_pkg::ASBL_SETUP;
        end
      end
      asbl_pkg::ASBL_SETUP: begin
        sel_d = 1'b1;
        cnt_d = asbl_pkg::CNT_W'(CYCLE_CYC);
        if (we_q) begin
          // Data drivers turn on together with the strobe while output enable stays high,
          // so the memory never drives at the same time.
          wstb_d = 1'b1;
          dqoe_d = 1'b1;
          cnt_d = asbl_pkg::CNT_W'(WPULSE_CYC + 1);
          state_d = asbl_pkg::ASBL_WR;
        end else begin
          // Host drivers are already off before output enable goes low.
          dqoe_d = 1'b0;
          oe_d = 1'b1;
          // The wait covers data settling plus the sampling stages before the capture.
          cnt_d = asbl_pkg::CNT_W'(RDATA_CYC + asbl_pkg::SYNC_STAGES);
          state_d = asbl_pkg::ASBL_RD;
        end
      end
      asbl_pkg::ASBL_RD: begin
        if (cnt_q == CNT_ONE) begin
          rdata_d = dq_s2_q;
          // Unselected lanes are released by the memory, so their bits are forced to zero here.
          if (!lanes_q[0]) rdata_d[LW-1:0] = '0;
          if (!lanes_q[1]) rdata_d[2*LW-1:LW] = '0;
          oe_d = 1'b0;
          sel_d = 1'b0;
          ack_d = 1'b1;
          cnt_d = asbl_pkg::CNT_W'(HZ_CYC);
          state_d = asbl_pkg::ASBL_RECOV;
        end
      end
      asbl_pkg::ASBL_WR: begin
        if (cnt_q == CNT_ONE) begin
          // The strobe alone ends the write; data and selects hold one cycle past it.
          wstb_d = 1'b0;
          cnt_d = CNT_ONE;
          state_d = asbl_pkg::ASBL_END;
        end
      end
      asbl_pkg::ASBL_END: begin
        // Selects drop with the strobe already high, so the memory stays released.
        sel_d = 1'b0;
        dqoe_d = 1'b0;
        ack_d = 1'b1;
        cnt_d = asbl_pkg::CNT_W'(HZ_CYC);
        state_d = asbl_pkg::ASBL_RECOV;
      end
      asbl_pkg::ASBL_RECOV: begin
        // Idle gap lets the bus float and keeps accesses apart by a full cycle time.
        if (cnt_q <= CNT_ONE) state_d = asbl_pkg::ASBL_IDLE;
      end
      default: begin
        state_d = asbl_pkg::ASBL_IDLE;
        sel_d = 1'b0;
        wstb_d = 1'b0;
        oe_d = 1'b0;
        dqoe_d = 1'b0;
      end
    endcase
  end

  // Reset leaves every pin at its idle level, so the memory starts in standby.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= asbl_pkg::ASBL_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      lanes_q <= asbl_pkg::LANES_NONE;
      we_q <= 1'b0;
      sel_q <= 1'b0;
      wstb_q <= 1'b0;
      oe_q <= 1'b0;
      dqoe_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      lanes_q <= lanes_d;
      we_q <= we_d;
      sel_q <= sel_d;
      wstb_q <= wstb_d;
      oe_q <= oe_d;
      dqoe_q <= dqoe_d;
      ack_q <= ack_d;
    end
  end

  // Between accesses both selects are inactive, putting the memory in standby.
  assign o_select_active_low = ~sel_q;
  assign o_select_active_high = sel_q;
  // Only requested lanes are gated on, so the other byte is left untouched.
  assign o_lower_lane_gate_n = ~(sel_q & lanes_q[0]);
  assign o_upper_lane_gate_n = ~(sel_q & lanes_q[1]);
  // Every pin below except o_busy comes straight from a flip-flop, so none of them can glitch mid-cycle.
  assign o_write_n = ~wstb_q;
  assign o_out_en_n = ~oe_q;
  assign o_mem_addr = addr_q;
  assign o_mem_dq = wdata_q;
  assign o_mem_dq_oe = dqoe_q;
  assign o_rdata = rdata_q;
  assign o_ack = ack_q;
  assign o_busy = (state_q != asbl_pkg::ASBL_IDLE);
endmodule // asbl_host
`default_nettype wire

// ---- verification/asbl_mem.sv ----
// Purpose: Behavioural static memory on the host pins.
// Assumes: Writes land at clock edges while every enable overlaps.
// Notes: Released pins toggle each cycle, so a stale value never passes.
`timescale 1ns/1ps
`default_nettype none
module asbl_mem (
  input wire logic i_clk,
  input wire logic [18:0] i_addr,
  input wire logic i_select_active_low,
  input wire logic i_select_active_high,
  input wire logic i_write_n,
  input wire logic i_out_en_n,
  input wire logic i_upper_lane_gate_n,
  input wire logic i_lower_lane_gate_n,
  input wire logic [15:0] i_host_dq,
  input wire logic i_host_dq_oe,
  output logic [15:0] o_dq
);
  logic [15:0] mem [bit [18:0]];
  logic [15:0] last_q = 16'h0000;
  logic [1:0] lane;
  logic [15:0] word;
  always_comb begin
    lane = {!i_upper_lane_gate_n, !i_lower_lane_gate_n};
    if (i_select_active_low || !i_select_active_high) lane = 2'h0;
    word = mem.exists(i_addr) ? mem[i_addr] : ~last_q;
    o_dq = ~last_q;
    for (int i = 0; i < 16; i++) begin
      if (i_host_dq_oe) o_dq[i] = i_host_dq[i];
      else if (lane[i/8] && i_write_n && !i_out_en_n) o_dq[i] = word[i];
    end
  end
  always @(posedge i_clk) begin
    last_q <= o_dq;
    for (int i = 0; i < 16; i++) begin
      if (!i_write_n && lane[i/8]) mem[i_addr][i] <= i_host_dq[i];
    end
  end
endmodule // asbl_mem
`default_nettype wire

// ---- verification/asbl_host_chk.sv ----
// Purpose: Pin order checks for the static memory host.
// Assumes: Default timing parameters of one cycle each.
// Notes: Bound to every host instance.
`timescale 1ns/1ps
`default_nettype none
module asbl_host_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [1:0] i_lanes,
  input wire logic o_ack,
  input wire logic o_busy,
  input wire logic [18:0] o_mem_addr,
  input wire logic o_select_active_low,
  input wire logic o_select_active_high,
  input wire logic o_write_n,
  input wire logic o_out_en_n,
  input wire logic o_upper_lane_gate_n,
  input wire logic o_lower_lane_gate_n,
  input wire logic [15:0] o_mem_dq,
  input wire logic o_mem_dq_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire sel = !o_select_active_low && o_select_active_high;
  sequence s_take;
    !o_busy && i_req && i_lanes != 2'h0;
  endsequence
  sequence s_sel_on;
    $fell(o_select_active_low);
  endsequence
  a_wr_ack: assert property (s_take ##0 i_we |-> ##5 o_ack) else $error("write ack");
  a_rd_ack: assert property (s_take ##0 !i_we |-> ##5 o_ack) else $error("read ack");
  a_rd_oe: assert property (s_take ##0 !i_we |-> ##2 (!o_out_en_n)[*3] ##1 o_out_en_n)
    else $error("read enable");
  a_desel_quiet: assert property ($rose(o_select_active_low) |-> o_write_n && $past(o_write_n))
    else $error("deselect during write");
  a_wr_oe_off: assert property (!o_write_n |-> o_out_en_n)
    else $error("output enable during write");
  a_addr_first: assert property (s_sel_on |-> $stable(o_mem_addr)
    && {o_upper_lane_gate_n, o_lower_lane_gate_n} == ~i_lanes) else $error("address order");
  a_idle_off: assert property (!o_busy |-> !sel && o_write_n && !o_mem_dq_oe)
    else $error("idle pins");
  a_no_fight: assert property (!(o_mem_dq_oe && !o_out_en_n)) else $error("contention");
  a_wr_gated: assert property (!o_write_n |-> sel && o_mem_dq_oe)
    else $error("write gating");
  a_wr_hold: assert property ($rose(o_write_n) |-> sel && o_mem_dq_oe
    && $stable(o_mem_dq) && $stable(o_mem_addr)) else $error("write hold");
  a_ack_once: assert property (o_ack |=> !o_ack) else $error("ack width");
endmodule // asbl_host_chk
bind asbl_host asbl_host_chk asbl_host_chk_i (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_req(i_req),
  .i_we(i_we),
  .i_lanes(i_lanes),
  .o_ack(o_ack),
  .o_busy(o_busy),
  .o_mem_addr(o_mem_addr),
  .o_select_active_low(o_select_active_low),
  .o_select_active_high(o_select_active_high),
  .o_write_n(o_write_n),
  .o_out_en_n(o_out_en_n),
  .o_upper_lane_gate_n(o_upper_lane_gate_n),
  .o_lower_lane_gate_n(o_lower_lane_gate_n),
  .o_mem_dq(o_mem_dq),
  .o_mem_dq_oe(o_mem_dq_oe)
);
`default_nettype wire

// ---- verification/async_sram_byte_lane_port_bench.sv ----
// Purpose: Random word and byte traffic through the static memory host.
// Assumes: Fields stay held until the ack.
// Notes: Each access notes its expected result for the ack monitor.
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_lane_port_bench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req = 1'b0;
  logic i_we = 1'b0;
  logic [18:0] i_addr = 19'h0_0000;
  logic [1:0] i_lanes = 2'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] o_rdata, o_mem_dq, i_mem_dq;
  logic [18:0] o_mem_addr;
  logic o_ack, o_busy, o_select_active_low, o_select_active_high, o_write_n, o_out_en_n;
  logic o_upper_lane_gate_n, o_lower_lane_gate_n, o_mem_dq_oe;
  int err_count = 0;
  int checks = 0;
  bit [15:0] mdl [bit [18:0]];
  logic [16:0] notes [$];
  logic [16:0] note;
  always #50 i_clk = ~i_clk;
  asbl_host asbl_host_i (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(i_req),
    .i_we(i_we),
    .i_addr(i_addr),
    .i_lanes(i_lanes),
    .i_wdata(i_wdata),
    .o_ack(o_ack),
    .o_rdata(o_rdata),
    .o_busy(o_busy),
    .o_mem_addr(o_mem_addr),
    .o_select_active_low(o_select_active_low),
    .o_select_active_high(o_select_active_high),
    .o_write_n(o_write_n),
    .o_out_en_n(o_out_en_n),
    .o_upper_lane_gate_n(o_upper_lane_gate_n),
    .o_lower_lane_gate_n(o_lower_lane_gate_n),
    .o_mem_dq(o_mem_dq),
    .o_mem_dq_oe(o_mem_dq_oe),
    .i_mem_dq(i_mem_dq)
  );
  asbl_mem asbl_mem_i (.i_clk(i_clk), .i_addr(o_mem_addr),
    .i_select_active_low(o_select_active_low), .i_select_active_high(o_select_active_high),
    .i_write_n(o_write_n), .i_out_en_n(o_out_en_n), .i_upper_lane_gate_n(o_upper_lane_gate_n),
    .i_lower_lane_gate_n(o_lower_lane_gate_n), .i_host_dq(o_mem_dq),
    .i_host_dq_oe(o_mem_dq_oe), .o_dq(i_mem_dq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic access(input logic we, input logic [18:0] a, input logic [1:0] ln,
                        input logic [15:0] d);
    logic [15:0] m;
    int n;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    @(posedge i_clk);
    i_req <= 1'b1;
    i_we <= we;
    i_addr <= a;
    i_lanes <= ln;
    i_wdata <= d;
    if (we) mdl[a] = (mdl[a] & ~m) | (d & m);
    notes.push_back({we, mdl[a] & m});
    n = 0;
    do @(negedge i_clk); while (o_ack !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      err_count++;
      results();
    end else begin
      @(posedge i_clk);
      i_req <= 1'b0;
    end
  endtask
  always @(negedge i_clk) begin
    if (o_ack === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (!note[16]) check(o_rdata, note[15:0]);
    end else if (o_ack === 1'b1) begin
      check({15'h0000, o_ack}, 16'h0000);
    end
  end
  initial begin
    logic [18:0] a;
    void'($urandom(32'h9968));
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 30; k++) begin
      a = 19'($urandom);
      access(1'b1, a, 2'h3, 16'($urandom));
      access(1'b1, a, 2'($urandom_range(2, 1)), 16'($urandom));
      access(1'b0, a, 2'($urandom_range(3, 1)), 16'h0000);
    end
    // A request with neither lane gated is refused and must leave the host idle.
    @(posedge i_clk);
    i_req <= 1'b1;
    i_lanes <= 2'h0;
    repeat (3) @(posedge i_clk);
    i_req <= 1'b0;
    @(negedge i_clk);
    check({15'h0000, o_busy}, 16'h0000);
    // A reset in mid-run clears the read data but leaves the memory contents alone.
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    check(o_rdata, 16'h0000);
    access(1'b0, a, 2'h3, 16'h0000);
    results();
  end
endmodule // async_sram_byte_lane_port_bench
`default_nettype wire
